// file: hw/pif_pkg.sv
package pif_pkg;

	// ==========================================================
	// Bus and register map
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFS_FLAG    = 8'h00;
	localparam logic [7:0]  OFS_STATUS  = 8'h04;
	localparam logic [7:0]  OFS_CLEAR   = 8'h08;
	localparam logic [7:0]  OFS_ENABLE  = 8'h0C;
	localparam logic [7:0]  OFS_CAUSE   = 8'h10;
	localparam logic [7:0]  OFS_OVERRUN = 8'h14;

	// ==========================================================
	// Flag layout
	localparam int          NFLAG       = 4;
	localparam int          BIT_OVF     = 0;
	localparam int          BIT_PMATCH  = 1;
	localparam int          BIT_CCP     = 2;
	localparam int          BIT_SERIAL  = 3;

	// ==========================================================
	// Serial port cause layout
	localparam int          NCAUSE      = 5;
	localparam int          CAUSE_STOP  = 0;
	localparam int          CAUSE_RSTRT = 1;
	localparam int          CAUSE_ACK   = 2;
	localparam int          CAUSE_BSTRT = 3;
	localparam int          CAUSE_BSTOP = 4;

	// ==========================================================
	// Reset values
	localparam logic [NFLAG-1:0]  RST_FLAGS  = 4'h0;
	localparam logic [NFLAG-1:0]  RST_ENABLE = 4'h0;
	localparam logic [NCAUSE-1:0] RST_CAUSE  = 5'h00;

	// ==========================================================
	// Capture/compare unit operating mode
	typedef enum logic [1:0] {
		PIF_CC_OFF,
		PIF_CC_CAPTURE,
		PIF_CC_COMPARE,
		PIF_CC_PWM
	} pif_ccmode_t;

endpackage

// file: hw/pif_reg_if.sv
`timescale 1ns/10ps
interface pif_reg_if;
	import pif_pkg::*;
	logic                wr_en;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [DATA_W-1:0]   rdata;

	modport bus  (output wr_en, output addr, output wdata, input rdata);
	modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface

// file: hw/pif_apb_slave.sv
`timescale 1ns/10ps
module pif_apb_slave (
	input  wire logic                          pclk,     // System clock
	input  wire logic                          presetn,  // Async reset, active low
	input  wire logic                          psel,     // APB select
	input  wire logic                          penable,  // APB access phase
	input  wire logic                          pwrite,   // APB direction
	input  wire logic [pif_pkg::ADDR_W-1:0]    paddr,    // APB byte address
	input  wire logic [pif_pkg::DATA_W-1:0]    pwdata,   // APB write data
	input  wire logic [3:0]                    pstrb,    // APB byte strobes
	output logic      [pif_pkg::DATA_W-1:0]    prdata,   // APB read data
	output logic                               pready,   // APB ready
	output logic                               pslverr,  // APB error
	pif_reg_if.bus                             rif       // Register access
);
	import pif_pkg::*;

	// ==========================================================
	// Address decode
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_FLAG) || (a == OFS_STATUS) || (a == OFS_CLEAR) ||
			(a == OFS_ENABLE) || (a == OFS_CAUSE) || (a == OFS_OVERRUN);
	endfunction

	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;

	// Zero wait states; only the low byte lane holds register bits
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~is_mapped(paddr);
	assign rif.wr_en = psel & penable & pwrite & pstrb[0] & is_mapped(paddr);
	assign rif.addr  = paddr;
	assign rif.wdata = pwdata;
	assign prdata    = prdata_r;

	// Read data is captured in the setup cycle, valid through access
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel & ~penable & ~pwrite) begin
			prdata_nxt = rif.rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(psel & penable & ~is_mapped(paddr)) |-> (pslverr & ~rif.wr_en))
		else $error("unmapped access not refused");

endmodule // pif_apb_slave

// file: hw/pif_flag_bank.sv
`timescale 1ns/10ps
module pif_flag_bank #(
	parameter int           W   = 4,    // Number of sticky bits
	parameter logic [W-1:0] RST = '0    // Reset value
) (
	input  wire logic          pclk,     // System clock
	input  wire logic          presetn,  // Async reset, active low
	input  wire logic [W-1:0]  set,      // Hardware set strobes
	input  wire logic [W-1:0]  clr,      // Software clear strobes
	output logic      [W-1:0]  q         // Sticky bits
);
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	assign q = q_r;

	// Set wins over a clear in the same cycle
	always_comb begin
		q_nxt = (q_r & ~clr) | set; // RULE12
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		##1 ((q_r & $past(set)) == $past(set)))
		else $error("set event lost");

	chk_clear_takes: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		##1 ((q_r & $past(clr) & ~$past(set)) == '0))
		else $error("clear did not take");

	chk_bits_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		##1 ((q_r & ~$past(q_r) & ~$past(set)) == '0))
		else $error("bit set without cause");

endmodule // pif_flag_bank

// file: hw/pif_top.sv
`timescale 1ns/10ps
// Contract
// RULE1: A stop condition that the serial port started as bus master sets its flag when it completes.
// RULE2: A repeated start that the serial port started sets its flag when it completes.
// RULE3: An acknowledge sequence that the serial port started sets its flag when it completes.
// RULE4: A start condition placed by another master while the serial port is idle sets its flag.
// RULE5: A stop condition seen on the bus while the serial port is idle sets its flag.
// RULE6: A clear serial port flag means no setting condition has come since the last clear.
// RULE7: In capture mode a capture of the wide timer sets the capture/compare flag at bit 2.
// RULE8: In compare mode a wide timer match with the compare value sets the capture/compare flag.
// RULE9: In PWM mode the capture/compare unit never sets its flag.
// RULE10: The narrow timer reaching its period sets the period match flag at bit 1.
// RULE11: An overflow of the wide timer sets the overflow flag at bit 0.
// RULE12: Flags stay set until software clears them, and a set in the clearing cycle wins.
module pif_top (
	input  wire logic                          pclk,                 // System clock
	input  wire logic                          presetn,              // Async reset, active low
	input  wire logic                          psel,                 // APB select
	input  wire logic                          penable,              // APB access phase
	input  wire logic                          pwrite,               // APB direction
	input  wire logic [pif_pkg::ADDR_W-1:0]    paddr,                // APB byte address
	input  wire logic [pif_pkg::DATA_W-1:0]    pwdata,               // APB write data
	input  wire logic [3:0]                    pstrb,                // APB byte strobes
	output logic      [pif_pkg::DATA_W-1:0]    prdata,               // APB read data
	output logic                               pready,               // APB ready
	output logic                               pslverr,              // APB error
	input  wire logic                          ssport_stop_done,     // Own stop condition finished
	input  wire logic                          ssport_restart_done,  // Own repeated start finished
	input  wire logic                          ssport_ack_done,      // Own acknowledge finished
	input  wire logic                          ssport_bus_start,     // Start condition seen on bus
	input  wire logic                          ssport_bus_stop,      // Stop condition seen on bus
	input  wire logic                          ssport_idle,          // Serial port is idle
	input  pif_pkg::pif_ccmode_t               capcomp_mode,         // Capture/compare unit mode
	input  wire logic                          capcomp_capture,      // Wide timer value captured
	input  wire logic                          capcomp_match,        // Wide timer equals compare value
	input  wire logic                          narrow_timer_match,   // Narrow timer equals period
	input  wire logic                          wide_timer_overflow,  // Wide timer overflowed
	output logic                               irq                   // Interrupt, active high level
);
	import pif_pkg::*;

	// ==========================================================
	// Declarations
	pif_reg_if rif ();

	logic [NFLAG-1:0]  flag_q;
	logic [NFLAG-1:0]  flag_set;
	logic [NFLAG-1:0]  flag_clr;
	logic [NCAUSE-1:0] cause_q;
	logic [NCAUSE-1:0] cause_set;
	logic [NCAUSE-1:0] cause_clr;
	logic [NFLAG-1:0]  ovr_q;
	logic [NFLAG-1:0]  ovr_set;
	logic [NFLAG-1:0]  ovr_clr;
	logic [NFLAG-1:0]  en_r;
	logic [NFLAG-1:0]  en_nxt;
	logic              irq_r;
	logic              irq_nxt;
	logic              serial_evt;
	logic              ccp_evt;

	// ==========================================================
	// Register bus
	pif_apb_slave u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rif     (rif.bus)
	);

	// ==========================================================
	// Event qualification
	always_comb begin
		cause_set              = '0;
		cause_set[CAUSE_STOP]  = ssport_stop_done;                 // RULE1
		cause_set[CAUSE_RSTRT] = ssport_restart_done;              // RULE2
		cause_set[CAUSE_ACK]   = ssport_ack_done;                  // RULE3
		cause_set[CAUSE_BSTRT] = ssport_bus_start & ssport_idle;   // RULE4
		cause_set[CAUSE_BSTOP] = ssport_bus_stop & ssport_idle;    // RULE5
	end

	// Only qualified conditions reach the serial flag
	assign serial_evt = |cause_set; // RULE6

	// PWM and off modes leave the flag alone
	assign ccp_evt = ((capcomp_mode == PIF_CC_CAPTURE) & capcomp_capture) | // RULE7
		((capcomp_mode == PIF_CC_COMPARE) & capcomp_match);                 // RULE8 RULE9

	always_comb begin
		flag_set             = '0;
		flag_set[BIT_OVF]    = wide_timer_overflow;  // RULE11
		flag_set[BIT_PMATCH] = narrow_timer_match;   // RULE10
		flag_set[BIT_CCP]    = ccp_evt;              // RULE7 RULE8
		flag_set[BIT_SERIAL] = serial_evt;           // RULE1 RULE2 RULE3 RULE4 RULE5
	end

	// Event arriving on a flag that is already pending
	assign ovr_set = flag_set & flag_q;

	// ==========================================================
	// Software clears
	always_comb begin
		flag_clr = '0;
		if (rif.wr_en) begin
			if (rif.addr == OFS_FLAG) begin
				flag_clr = ~rif.wdata[NFLAG-1:0]; // RULE12
			end else if (rif.addr == OFS_CLEAR) begin
				flag_clr = rif.wdata[NFLAG-1:0];
			end
		end
	end

	// Cause and overrun history go with their flag
	assign cause_clr = {NCAUSE{flag_clr[BIT_SERIAL]}};
	assign ovr_clr   = flag_clr;

	// ==========================================================
	// Sticky storage
	pif_flag_bank #(
		.W   (NFLAG),
		.RST (RST_FLAGS)
	) u_flags (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (flag_set),
		.clr     (flag_clr),
		.q       (flag_q)
	);

	pif_flag_bank #(
		.W   (NCAUSE),
		.RST (RST_CAUSE)
	) u_cause (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (cause_set),
		.clr     (cause_clr),
		.q       (cause_q)
	);

	pif_flag_bank #(
		.W   (NFLAG),
		.RST (RST_FLAGS)
	) u_ovr (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (ovr_set),
		.clr     (ovr_clr),
		.q       (ovr_q)
	);

	// ==========================================================
	// Enable register and interrupt output
	always_comb begin
		en_nxt = en_r;
		if (rif.wr_en && (rif.addr == OFS_ENABLE)) begin
			en_nxt = rif.wdata[NFLAG-1:0];
		end
		irq_nxt = |(flag_q & en_r);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r  <= RST_ENABLE;
			irq_r <= 1'b0;
		end else begin
			en_r  <= en_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign irq = irq_r;

	// ==========================================================
	// Read data
	always_comb begin
		rif.rdata = '0;
		if ((rif.addr == OFS_FLAG) || (rif.addr == OFS_STATUS)) begin
			rif.rdata[NFLAG-1:0] = flag_q;
		end else if (rif.addr == OFS_ENABLE) begin
			rif.rdata[NFLAG-1:0] = en_r;
		end else if (rif.addr == OFS_CAUSE) begin
			rif.rdata[NCAUSE-1:0] = cause_q;
		end else if (rif.addr == OFS_OVERRUN) begin
			rif.rdata[NFLAG-1:0] = ovr_q;
		end
	end

	// ==========================================================
	// Checks
	chk_own_stop_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		ssport_stop_done |=> (flag_q[BIT_SERIAL] & cause_q[CAUSE_STOP]))
		else $error("own stop did not set serial flag");

	chk_own_restart_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		ssport_restart_done |=> (flag_q[BIT_SERIAL] & cause_q[CAUSE_RSTRT]))
		else $error("own restart did not set serial flag");

	chk_own_ack_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		ssport_ack_done |=> (flag_q[BIT_SERIAL] & cause_q[CAUSE_ACK]))
		else $error("own acknowledge did not set serial flag");

	chk_idle_start_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		(ssport_bus_start & ssport_idle) |=> (flag_q[BIT_SERIAL] & cause_q[CAUSE_BSTRT]))
		else $error("bus start while idle did not set serial flag");

	chk_idle_stop_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		(ssport_bus_stop & ssport_idle) |=> (flag_q[BIT_SERIAL] & cause_q[CAUSE_BSTOP]))
		else $error("bus stop while idle did not set serial flag");

	chk_serial_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		$rose(flag_q[BIT_SERIAL]) |-> ($past(serial_evt) & (cause_q != '0)))
		else $error("serial flag rose without a condition");

	chk_busy_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(~flag_q[BIT_SERIAL] & ~ssport_idle & ~ssport_stop_done & ~ssport_restart_done
			& ~ssport_ack_done) |=> ~flag_q[BIT_SERIAL])
		else $error("serial flag set while busy without own condition");

	chk_capture_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		((capcomp_mode == PIF_CC_CAPTURE) & capcomp_capture) |=> flag_q[BIT_CCP])
		else $error("capture did not set capture/compare flag");

	chk_compare_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		((capcomp_mode == PIF_CC_COMPARE) & capcomp_match) |=> flag_q[BIT_CCP])
		else $error("compare match did not set capture/compare flag");

	chk_pwm_silent: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		((capcomp_mode == PIF_CC_PWM) & ~flag_q[BIT_CCP]) |=> ~flag_q[BIT_CCP])
		else $error("capture/compare flag set in pwm mode");

	chk_period_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		narrow_timer_match |=> flag_q[BIT_PMATCH] [*1] ##0 (rif.rdata[BIT_PMATCH] | (rif.addr != OFS_FLAG)))
		else $error("period match did not set its flag");

	chk_overflow_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		wide_timer_overflow |=> flag_q[BIT_OVF])
		else $error("overflow did not set its flag");

	chk_write_zero_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(rif.wr_en & (rif.addr == OFS_FLAG) & ~rif.wdata[BIT_OVF] & ~wide_timer_overflow)
			|=> ~flag_q[BIT_OVF])
		else $error("writing zero did not clear the overflow flag");

	chk_write_one_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(rif.wr_en & (rif.addr == OFS_FLAG) & rif.wdata[BIT_PMATCH] & flag_q[BIT_PMATCH])
			|=> flag_q[BIT_PMATCH])
		else $error("writing one cleared the period match flag");

	chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
		##1 (irq == |($past(flag_q) & $past(en_r))))
		else $error("interrupt does not follow enabled flags");

	chk_clear_reg_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(rif.wr_en & (rif.addr == OFS_CLEAR) & rif.wdata[BIT_PMATCH] & ~narrow_timer_match)
			|=> ~flag_q[BIT_PMATCH])
		else $error("clear register did not clear the period match flag");

	chk_clear_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(rif.wr_en & (rif.addr == OFS_FLAG) & ~rif.wdata[BIT_OVF] & wide_timer_overflow)
			|=> flag_q[BIT_OVF])
		else $error("overflow lost against a clearing write");

	chk_cause_cleared: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(rif.wr_en & (rif.addr == OFS_CLEAR) & rif.wdata[BIT_SERIAL] & ~ssport_stop_done
			& ~ssport_restart_done & ~ssport_ack_done & ~ssport_bus_start & ~ssport_bus_stop)
			|=> ((cause_q == '0) & ~flag_q[BIT_SERIAL]))
		else $error("serial flag or cause survived its clear");

	chk_pmatch_needs_event: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(~flag_q[BIT_PMATCH] & ~narrow_timer_match) |=> ~flag_q[BIT_PMATCH])
		else $error("period match flag set without a match");

	chk_ovf_needs_event: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(~flag_q[BIT_OVF] & ~wide_timer_overflow) |=> ~flag_q[BIT_OVF])
		else $error("overflow flag set without an overflow");

	chk_ccp_needs_event: assert property (@(posedge pclk) disable iff (!presetn) // RULE7 RULE8
		(~flag_q[BIT_CCP] & ~capcomp_capture & ~capcomp_match) |=> ~flag_q[BIT_CCP])
		else $error("capture/compare flag set without an event");

	chk_ccp_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(flag_q[BIT_CCP] & ~(rif.wr_en & (rif.addr == OFS_FLAG) & ~rif.wdata[BIT_CCP])
			& ~(rif.wr_en & (rif.addr == OFS_CLEAR) & rif.wdata[BIT_CCP])) |=> flag_q[BIT_CCP])
		else $error("capture/compare flag dropped without a clear");

	chk_serial_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(flag_q[BIT_SERIAL] & ~(rif.wr_en & (rif.addr == OFS_FLAG) & ~rif.wdata[BIT_SERIAL])
			& ~(rif.wr_en & (rif.addr == OFS_CLEAR) & rif.wdata[BIT_SERIAL])) |=> flag_q[BIT_SERIAL])
		else $error("serial flag dropped without a clear");

	chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		(en_r == '0) |=> ~irq)
		else $error("interrupt raised with all sources disabled");

	chk_overrun_marks: assert property (@(posedge pclk) disable iff (!presetn)
		(wide_timer_overflow & flag_q[BIT_OVF]) |=> ovr_q[BIT_OVF])
		else $error("repeated overflow not marked as overrun");

	chk_strobe_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(psel & penable & pwrite & ~pstrb[0] & (paddr == OFS_ENABLE)) |=> $stable(en_r))
		else $error("write without low byte lane changed the enable register");

endmodule // pif_top

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import pif_pkg::*;

	// ==========================================================
	// Signals
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [DATA_W-1:0]   pwdata;
	logic [DATA_W-1:0]   prdata;
	logic [3:0]          pstrb;
	logic                pready;
	logic                pslverr;
	logic                irq;
	logic                ssport_idle;
	logic [8:0]          ev;
	logic [8:0]          rev;
	pif_ccmode_t         capcomp_mode;
	logic [NFLAG-1:0]    model;
	logic [NFLAG-1:0]    msk;
	logic [DATA_W-1:0]   rdv;
	logic                err;
	int                  mismatches;
	int                  comparisons;

	pif_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ssport_stop_done(ev[0]), .ssport_restart_done(ev[1]),
		.ssport_ack_done(ev[2]), .ssport_bus_start(ev[3]), .ssport_bus_stop(ev[4]),
		.ssport_idle(ssport_idle), .capcomp_mode(capcomp_mode), .capcomp_capture(ev[5]),
		.capcomp_match(ev[6]), .narrow_timer_match(ev[7]), .wide_timer_overflow(ev[8]), .irq(irq));

	// ==========================================================
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		close_out();
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic close_out();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Events in e pulse during the access cycle, landing on the same edge as the transfer
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
			input logic [8:0] e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		if (e != '0)
			ev <= e;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		if (e != '0)
			ev <= '0;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'b1, a, d, 9'h000);
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(1'b0, a, 32'h0000_0000, 9'h000);
		check_word(rdv, exp);
	endtask

	task automatic pulse(input logic [8:0] e);
		ev <= e;
		@(posedge pclk);
		ev <= '0;
		@(posedge pclk);
	endtask

	task automatic irq_chk(input logic exp);
		@(posedge pclk);
		#1;
		check_bit(irq, exp);
	endtask

	function automatic logic [NFLAG-1:0] exp_set(input logic [8:0] e, input pif_ccmode_t m, input logic idle);
		exp_set = '0;
		if ((|e[2:0]) || (idle && (|e[4:3])))
			exp_set[BIT_SERIAL] = 1'b1;
		if ((e[5] && m == PIF_CC_CAPTURE) || (e[6] && m == PIF_CC_COMPARE))
			exp_set[BIT_CCP] = 1'b1;
		exp_set[BIT_PMATCH] = e[7];
		exp_set[BIT_OVF]    = e[8];
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		mismatches = 0;
		comparisons = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		ev = '0;
		ssport_idle = 1'b1;
		capcomp_mode = PIF_CC_OFF;
		void'($urandom(32'h6fba7539));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(OFS_FLAG, 32'h0000_0000);
		rdchk(OFS_CAUSE, 32'h0000_0000);
		rdchk(OFS_ENABLE, 32'h0000_0000);
		// Each serial cause alone, then cleared
		for (int i = 0; i < NCAUSE; i++) begin
			pulse(9'h001 << i);
			rdchk(OFS_STATUS, 32'h0000_0008);
			rdchk(OFS_CAUSE, 32'h1 << i);
			wr(OFS_CLEAR, 32'h0000_0008);
			rdchk(OFS_STATUS, 32'h0000_0000);
		end
		// Bus conditions while the port is busy do not count
		ssport_idle <= 1'b0;
		pulse(9'h018);
		rdchk(OFS_STATUS, 32'h0000_0000);
		ssport_idle <= 1'b1;
		// Capture and match events in every mode
		for (int m = 0; m < 4; m++) begin
			capcomp_mode <= pif_ccmode_t'(m);
			pulse(9'h020);
			rdchk(OFS_FLAG, {28'h0, exp_set(9'h020, pif_ccmode_t'(m), 1'b1)});
			wr(OFS_CLEAR, 32'h0000_0004);
			pulse(9'h040);
			rdchk(OFS_FLAG, {28'h0, exp_set(9'h040, pif_ccmode_t'(m), 1'b1)});
			wr(OFS_CLEAR, 32'h0000_0004);
		end
		pulse(9'h180);
		rdchk(OFS_FLAG, 32'h0000_0003);
		pulse(9'h100);
		rdchk(OFS_OVERRUN, 32'h0000_0001);
		wr(OFS_FLAG, 32'h0000_000E);
		repeat (5) @(posedge pclk);
		rdchk(OFS_FLAG, 32'h0000_0002);
		rdchk(OFS_OVERRUN, 32'h0000_0000);
		// Overflow on the very edge of a clearing write
		apb(1'b1, OFS_FLAG, 32'h0000_0000, 9'h100);
		rdchk(OFS_FLAG, 32'h0000_0001);
		// Interrupt enable, mask and clear
		wr(OFS_ENABLE, 32'h0000_0001);
		irq_chk(1'b1);
		wr(OFS_ENABLE, 32'h0000_0000);
		irq_chk(1'b0);
		wr(OFS_ENABLE, 32'h0000_000F);
		rdchk(OFS_ENABLE, 32'h0000_000F);
		wr(OFS_CLEAR, 32'h0000_000F);
		irq_chk(1'b0);
		// Unmapped address
		apb(1'b0, 8'h18, 32'h0000_0000, 9'h000);
		check_bit(err, 1'b1);
		check_word(rdv, 32'h0000_0000);
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 9'h000);
		check_bit(err, 1'b1);
		// A write without the low byte lane is dropped
		pstrb <= 4'hE;
		wr(OFS_ENABLE, 32'h0000_0000);
		check_bit(err, 1'b0);
		pstrb <= 4'hF;
		rdchk(OFS_ENABLE, 32'h0000_000F);
		// Random traffic against the flag model
		model = '0;
		for (int k = 0; k < 60; k++) begin
			@(posedge pclk);
			capcomp_mode <= pif_ccmode_t'($urandom_range(3, 0));
			ssport_idle  <= 1'($urandom);
			@(posedge pclk);
			rev = 9'($urandom);
			model = model | exp_set(rev, capcomp_mode, ssport_idle);
			pulse(rev);
			rdchk(OFS_STATUS, {28'h0, model});
			irq_chk(|model);
			msk = 4'($urandom);
			wr(OFS_CLEAR, {28'h0, msk});
			model = model & ~msk;
			irq_chk(|model);
		end
		close_out();
	end

endmodule // tb_top
